//--- irq_vector_pkg.sv
// package: vector addresses, priorities and source layout of the interrupt vectoring logic
package irq_vector_pkg;

   // ==========================================================
   // address window of the vector table
   // ==========================================================
   localparam logic [15:0] VEC_REGION_TOP = 16'hffff;
   localparam logic [15:0] VEC_REGION_BOTTOM = 16'hff80;

   // ==========================================================
   // source groups, numbered by table position
   // ==========================================================
   localparam int NUM_GROUPS = 12;
   localparam int GRP_RESET = 0;
   localparam int GRP_SYS_NMI = 1;
   localparam int GRP_USER_NMI = 2;
   localparam int GRP_TIMER_CH0 = 3;
   localparam int GRP_TIMER_OTHER = 4;
   localparam int GRP_RTC = 5;
   localparam int GRP_WATCHDOG = 6;
   localparam int GRP_SERIAL = 7;
   localparam int GRP_ADC = 8;
   localparam int GRP_PORT1 = 9;
   localparam int GRP_PORT2 = 10;
   localparam int GRP_COMPARATOR = 11;
   localparam int FIRST_MASKABLE = GRP_TIMER_CH0;

   typedef logic [15:0] vec_addr_t;
   typedef logic [5:0] prio_t;

   // vector word addresses by group
   localparam vec_addr_t VEC_ADDR [NUM_GROUPS] = '{
      16'hfffe, 16'hfffc, 16'hfffa, 16'hfff8, 16'hfff6, 16'hfff4,
      16'hfff2, 16'hfff0, 16'hffee, 16'hffec, 16'hffea, 16'hffe8};

   // priorities by group, higher wins
   localparam prio_t VEC_PRIO [NUM_GROUPS] = '{
      6'd63, 6'd62, 6'd61, 6'd60, 6'd59, 6'd58,
      6'd57, 6'd56, 6'd55, 6'd54, 6'd53, 6'd52};

   // ==========================================================
   // shared-vector index codes (even values except the lock-loss cause fh, zero means none)
   // ==========================================================
   localparam logic [3:0] IDX_NONE = 4'h0;
   localparam logic [3:0] IDX_SER_RX = 4'h2;
   localparam logic [3:0] IDX_SER_TX = 4'h4;
   localparam logic [3:0] IDX_SER_START = 4'h6;
   localparam logic [3:0] IDX_SER_TXCPT = 4'h8;
   localparam logic [3:0] IDX_PIN_STEP = 4'h2;

   // port pins that raise requests
   localparam logic [7:0] PORT1_PIN_MASK = 8'h0f;
   localparam logic [7:0] PORT2_PIN_MASK = 8'hc3;

   // reset-cause codes
   localparam logic [3:0] CAUSE_NONE = 4'h0;
   localparam logic [3:0] CAUSE_POWER = 4'h2;
   localparam logic [3:0] CAUSE_SUPERVISOR = 4'h4;
   localparam logic [3:0] CAUSE_PIN = 4'h6;
   localparam logic [3:0] CAUSE_WATCHDOG = 4'h8;
   localparam logic [3:0] CAUSE_BIT_ERROR = 4'ha;
   localparam logic [3:0] CAUSE_SOFT_POR = 4'hc;
   localparam logic [3:0] CAUSE_SOFT_BOR = 4'he;
   localparam logic [3:0] CAUSE_LOCK_LOSS = 4'hf;

endpackage : irq_vector_pkg

//--- pin_index_encoder.sv
// module: lowest-set-pin encoder for a shared port vector index
`timescale 1ns/100ps
module pin_index_encoder
   import irq_vector_pkg::*;
(
   input wire logic [7:0] flags,
   input wire logic [7:0] pin_mask,
   output logic [4:0] index
);

   // ==========================================================
   // priority encode, pin 0 first
   // ==========================================================
   logic [7:0] live;
   assign live = flags & pin_mask;

   always_comb
   begin
      index = 5'(IDX_NONE);
      for (int i = 7; i >= 0; i--)
      begin
         if (live[i])
         begin
            index = 5'((i + 1) * IDX_PIN_STEP);
         end
      end
   end

endmodule : pin_index_encoder

//--- interrupt_vector_priority.sv
// module: fixed-priority interrupt vectoring for the processor core
// Summary of operation
// R1: all vector words sit between ffffh and ff80h.
// R2: each vector is a 16-bit handler start address word.
// R3: reset group vectors through fffeh at priority 63.
// R4: system non-maskable group vectors through fffch at priority 62.
// R5: watchdog interval request vectors through fff2h at priority 57.
// R6: serial flags share fff0h, priority 56; mode selects flags; index names source.
// R7: port 1 pins 0-3 share ffech, priority 54, with index.
// R8: port 2 pins 0,1,6,7 share ffeah, priority 53, with index.
// R9: user nmi fffah/61, timers fff8h/60 fff6h/59, rtc fff4h/58, adc ffeeh/55, comp ffe8h/52.
// R10: highest pending priority wins; maskable only with global enable set.
`timescale 1ns/100ps
module interrupt_vector_priority
   import irq_vector_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   // reset group causes
   input wire logic power_up_flag,
   input wire logic supply_supervisor_flag,
   input wire logic pin_reset_flag,
   input wire logic watchdog_flag,
   input wire logic reset_bit_error_flag,
   input wire logic soft_por_flag,
   input wire logic soft_bor_flag,
   input wire logic lock_loss_reset_flag,
   // system nmi group
   input wire logic vacant_access_flag,
   input wire logic debug_mailbox_in_flag,
   input wire logic debug_mailbox_out_flag,
   input wire logic access_time_error_flag,
   input wire logic correctable_bit_error_flag,
   input wire logic uncorrectable_bit_error_flag,
   // user nmi group
   input wire logic external_nmi_flag,
   input wire logic oscillator_fault_flag,
   // maskable peripherals
   input wire logic timer_ch0_flag,
   input wire logic timer_other_flag,
   input wire logic rtc_flag,
   input wire logic watchdog_interval_flag,
   input wire logic serial_uart_mode,
   input wire logic serial_tx_complete_flag,
   input wire logic serial_start_bit_flag,
   input wire logic serial_rx_flag,
   input wire logic serial_tx_flag,
   input wire logic adc_flag,
   input wire logic comparator_flag,
   input wire logic [7:0] port1_change_flags,
   input wire logic [7:0] port2_change_flags,
   input wire logic global_enable,
   // core side
   output logic irq_pending,
   output logic is_reset_vector,
   output logic [15:0] vector_address,
   output logic [5:0] vector_priority,
   output logic [3:0] reset_cause_vector,
   output logic [3:0] serial_vector_index,
   output logic [4:0] port1_vector_index,
   output logic [4:0] port2_vector_index
);

   // ==========================================================
   // request collection
   // ==========================================================
   typedef enum logic [1:0] {IDLE = 2'b00, PENDING = 2'b01} arb_state_t;

   logic [NUM_GROUPS-1:0] raw_req;
   logic [NUM_GROUPS-1:0] enabled_req;
   logic reset_group;
   logic sys_nmi_group;
   logic user_nmi_group;
   logic serial_any;
   logic [4:0] next_port1_index;
   logic [4:0] next_port2_index;
   logic [3:0] next_serial_index;
   logic [3:0] next_cause;

   // reset group causes
   assign reset_group = power_up_flag | supply_supervisor_flag | pin_reset_flag
      | watchdog_flag | reset_bit_error_flag | soft_por_flag | soft_bor_flag
      | lock_loss_reset_flag; // R3
   assign sys_nmi_group = vacant_access_flag | debug_mailbox_in_flag
      | debug_mailbox_out_flag | access_time_error_flag
      | correctable_bit_error_flag | uncorrectable_bit_error_flag; // R4
   assign user_nmi_group = external_nmi_flag | oscillator_fault_flag; // R9

   // serial flags; start and complete only count in uart mode
   assign serial_any = serial_rx_flag | serial_tx_flag
      | (serial_uart_mode & (serial_tx_complete_flag | serial_start_bit_flag)); // R6

   // group request vector, in table order
   assign raw_req[GRP_RESET] = reset_group;
   assign raw_req[GRP_SYS_NMI] = sys_nmi_group;
   assign raw_req[GRP_USER_NMI] = user_nmi_group;
   assign raw_req[GRP_TIMER_CH0] = timer_ch0_flag; // R9
   assign raw_req[GRP_TIMER_OTHER] = timer_other_flag; // R9
   assign raw_req[GRP_RTC] = rtc_flag; // R9
   assign raw_req[GRP_WATCHDOG] = watchdog_interval_flag; // R5
   assign raw_req[GRP_SERIAL] = serial_any; // R6
   assign raw_req[GRP_ADC] = adc_flag; // R9
   assign raw_req[GRP_PORT1] = |(port1_change_flags & PORT1_PIN_MASK); // R7
   assign raw_req[GRP_PORT2] = |(port2_change_flags & PORT2_PIN_MASK); // R8
   assign raw_req[GRP_COMPARATOR] = comparator_flag; // R9

   // ==========================================================
   // masking by global enable
   // ==========================================================
   genvar g;
   generate
      for (g = 0; g < NUM_GROUPS; g++)
      begin : gen_mask
         if (g < FIRST_MASKABLE)
         begin : gen_nmi
            assign enabled_req[g] = raw_req[g];
         end
         else
         begin : gen_mskb
            assign enabled_req[g] = raw_req[g] & global_enable; // R10
         end
      end
   endgenerate

   // ==========================================================
   // winner selection: lowest table position is highest priority
   // ==========================================================
   function automatic logic [3:0] pick_group(input logic [NUM_GROUPS-1:0] req);
      logic [3:0] win;
      win = 4'(NUM_GROUPS - 1);
      for (int i = NUM_GROUPS - 1; i >= 0; i--)
      begin
         if (req[i])
         begin
            win = 4'(i);
         end
      end
      return win;
   endfunction : pick_group

   logic [3:0] winner;
   logic any_req;
   assign winner = pick_group(enabled_req); // R10
   assign any_req = |enabled_req;

   // ==========================================================
   // shared-vector index decode
   // ==========================================================
   pin_index_encoder u_port1_enc (
      .flags(port1_change_flags),
      .pin_mask(PORT1_PIN_MASK),
      .index(next_port1_index)
   ); // R7

   pin_index_encoder u_port2_enc (
      .flags(port2_change_flags),
      .pin_mask(PORT2_PIN_MASK),
      .index(next_port2_index)
   ); // R8

   // serial index: receive first, then transmit, start, complete
   assign next_serial_index = serial_rx_flag ? IDX_SER_RX :
      serial_tx_flag ? IDX_SER_TX :
      (serial_uart_mode & serial_start_bit_flag) ? IDX_SER_START :
      (serial_uart_mode & serial_tx_complete_flag) ? IDX_SER_TXCPT : IDX_NONE; // R6

   // reset cause, most severe first
   assign next_cause = power_up_flag ? CAUSE_POWER :
      supply_supervisor_flag ? CAUSE_SUPERVISOR :
      pin_reset_flag ? CAUSE_PIN :
      watchdog_flag ? CAUSE_WATCHDOG :
      reset_bit_error_flag ? CAUSE_BIT_ERROR :
      soft_por_flag ? CAUSE_SOFT_POR :
      soft_bor_flag ? CAUSE_SOFT_BOR :
      lock_loss_reset_flag ? CAUSE_LOCK_LOSS : CAUSE_NONE; // R3

   // ==========================================================
   // registered outputs toward the core
   // ==========================================================
   arb_state_t state;
   arb_state_t next_state;
   assign next_state = any_req ? PENDING : IDLE;

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state <= IDLE;
      end
      else
      begin
         state <= next_state;
      end
   end

   // pending flag follows the state
   always_comb
   begin
      case (state)
         IDLE: irq_pending = 1'b0;
         PENDING: irq_pending = 1'b1;
         default: irq_pending = 1'b0;
      endcase
   end

   // vector address and priority of the winner
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         vector_address <= VEC_ADDR[GRP_RESET]; // R1
         vector_priority <= VEC_PRIO[GRP_RESET];
         is_reset_vector <= 1'b1;
      end
      else
      begin
         vector_address <= any_req ? VEC_ADDR[winner] : VEC_ADDR[GRP_RESET]; // R2
         vector_priority <= any_req ? VEC_PRIO[winner] : 6'(0); // R10
         is_reset_vector <= any_req && (winner == 4'(GRP_RESET)); // R3
      end
   end

   // index registers for the shared vectors
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         reset_cause_vector <= CAUSE_NONE;
         serial_vector_index <= IDX_NONE;
         port1_vector_index <= 5'(IDX_NONE);
         port2_vector_index <= 5'(IDX_NONE);
      end
      else
      begin
         reset_cause_vector <= next_cause;
         serial_vector_index <= next_serial_index;
         port1_vector_index <= next_port1_index;
         port2_vector_index <= next_port2_index;
      end
   end

endmodule : interrupt_vector_priority

//--- irq_vector_checker_assertions.sv
// checker: concurrent properties on the vectoring block ports
`timescale 1ns/100ps
module irq_vector_checker
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic power_up_flag,
   input wire logic external_nmi_flag,
   input wire logic rtc_flag,
   input wire logic global_enable,
   input wire logic serial_rx_flag,
   input wire logic irq_pending,
   input wire logic is_reset_vector,
   input wire logic [15:0] vector_address,
   input wire logic [5:0] vector_priority,
   input wire logic [3:0] reset_cause_vector,
   input wire logic [3:0] serial_vector_index
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   // ==========================================================
   // vector word placement and selection
   // ==========================================================
   property p_pair;
      irq_pending |-> vector_address == {9'h1ff, vector_priority, 1'b0};
   endproperty
   a_pair: assert property (p_pair) else $error("address off priority");
   property p_region;
      irq_pending |-> vector_address >= 16'hff80 && !vector_address[0];
   endproperty
   a_region: assert property (p_region) else $error("address outside window");
   property p_rstvec;
      is_reset_vector |-> vector_address == 16'hfffe && vector_priority == 6'h3f;
   endproperty
   a_rstvec: assert property (p_rstvec) else $error("reset vector wrong");
   property p_por;
      !$past(sys_rst) && $past(power_up_flag) |-> is_reset_vector && reset_cause_vector == 4'h2;
   endproperty
   a_por: assert property (p_por) else $error("power cause lost");
   property p_nmi;
      !$past(sys_rst) && $past(external_nmi_flag) |-> irq_pending && vector_priority >= 6'h3d;
   endproperty
   a_nmi: assert property (p_nmi) else $error("user nmi lost");
   property p_rtc;
      !$past(sys_rst) && $past(rtc_flag && global_enable) |-> irq_pending
         && vector_priority >= 6'h3a;
   endproperty
   a_rtc: assert property (p_rtc) else $error("rtc request lost");
   property p_mask;
      $past(!global_enable) && irq_pending |-> vector_priority >= 6'h3d;
   endproperty
   a_mask: assert property (p_mask) else $error("masked source granted");
   property p_ser;
      !$past(sys_rst) && $past(serial_rx_flag) |-> serial_vector_index == 4'h2;
   endproperty
   a_ser: assert property (p_ser) else $error("serial index wrong");
   // main scenarios seen
   c_reset: cover property (is_reset_vector && !$past(sys_rst));
   c_masked: cover property ($past(!global_enable) && irq_pending);
   c_start: cover property (serial_vector_index == 4'h6);
endmodule : irq_vector_checker

bind interrupt_vector_priority irq_vector_checker i_chk (.clk(clk), .sys_rst(sys_rst),
   .power_up_flag(power_up_flag), .external_nmi_flag(external_nmi_flag), .rtc_flag(rtc_flag),
   .global_enable(global_enable), .serial_rx_flag(serial_rx_flag), .irq_pending(irq_pending),
   .is_reset_vector(is_reset_vector), .vector_address(vector_address),
   .vector_priority(vector_priority), .reset_cause_vector(reset_cause_vector),
   .serial_vector_index(serial_vector_index));

//--- core_vector_fetch.sv
// partner: core model reading the vector word the block points at
`timescale 1ns/100ps
module core_vector_fetch
   import irq_vector_pkg::*;
(
   input wire logic irq_pending,
   input wire logic [15:0] vector_address,
   output logic [15:0] handler_word,
   output logic stray_fetch
);
   // each vector word holds a handler start address made from its location
   assign handler_word = irq_pending ? {~vector_address[7:0], vector_address[7:0]} : 16'h0;
   assign stray_fetch = irq_pending && (vector_address < VEC_REGION_BOTTOM);
endmodule : core_vector_fetch

//--- tb_interrupt_vector_priority.sv
// testbench: walking and random requests against the vectoring block
`timescale 1ns/100ps
module tb_interrupt_vector_priority
   import irq_vector_pkg::*;
;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [43:0] v = '0;
   logic [7:0] rs, p1, p2;
   logic [5:0] sn, mk, prio;
   logic [3:0] se, cause, sidx;
   logic [1:0] un;
   logic um, ge, pend, isr, stray;
   logic [15:0] addr, word;
   logic [4:0] i1, i2;
   logic [58:0] got;
   int failures = 0;
   int num_checks = 0;
   // outputs while reset is held: reset vector shown, nothing pending, indexes clear
   localparam logic [58:0] RESET_OUT = {2'b01, 16'hfffe, 6'h3f, 18'h0, 16'h0, 1'b0};
   assign {ge, p2, p1, um, se, mk, un, sn, rs} = v;
   assign got = {pend, isr, addr, prio, cause, sidx, i1, i2, word, stray};
   always #20 clk = ~clk;
   // ==========================================================
   // block and core model
   // ==========================================================
   interrupt_vector_priority i_dut (.clk(clk), .sys_rst(sys_rst), .power_up_flag(rs[0]),
      .supply_supervisor_flag(rs[1]), .pin_reset_flag(rs[2]), .watchdog_flag(rs[3]),
      .reset_bit_error_flag(rs[4]), .soft_por_flag(rs[5]), .soft_bor_flag(rs[6]),
      .lock_loss_reset_flag(rs[7]), .vacant_access_flag(sn[0]), .debug_mailbox_in_flag(sn[1]),
      .debug_mailbox_out_flag(sn[2]), .access_time_error_flag(sn[3]),
      .correctable_bit_error_flag(sn[4]), .uncorrectable_bit_error_flag(sn[5]),
      .external_nmi_flag(un[0]), .oscillator_fault_flag(un[1]), .timer_ch0_flag(mk[0]),
      .timer_other_flag(mk[1]), .rtc_flag(mk[2]), .watchdog_interval_flag(mk[3]),
      .adc_flag(mk[4]), .comparator_flag(mk[5]), .serial_uart_mode(um), .serial_rx_flag(se[0]),
      .serial_tx_flag(se[1]), .serial_start_bit_flag(se[2]), .serial_tx_complete_flag(se[3]),
      .port1_change_flags(p1), .port2_change_flags(p2), .global_enable(ge), .irq_pending(pend),
      .is_reset_vector(isr), .vector_address(addr), .vector_priority(prio),
      .reset_cause_vector(cause), .serial_vector_index(sidx), .port1_vector_index(i1),
      .port2_vector_index(i2));
   core_vector_fetch i_core (.irq_pending(pend), .vector_address(addr), .handler_word(word),
      .stray_fetch(stray));
   // ==========================================================
   // expected outputs for one input pattern
   // ==========================================================
   function automatic logic [58:0] expect_out(input logic [43:0] x);
      logic [11:0] g;
      logic [15:0] a;
      logic [3:0] c;
      logic [4:0] j1, j2;
      logic [7:0] m1, m2;
      int w;
      m1 = x[34:27] & PORT1_PIN_MASK;
      m2 = x[42:35] & PORT2_PIN_MASK;
      g[2:0] = {|x[15:14], |x[13:8], |x[7:0]};
      g[11:3] = {9{x[43]}} & {x[21], |m2, |m1, x[20],
         x[22] | x[23] | (x[26] & (x[24] | x[25])), x[19], x[18], x[17], x[16]};
      w = 12;
      c = 4'h0;
      j1 = 5'h0;
      j2 = 5'h0;
      for (int i = 11; i >= 0; i--)
         if (g[i]) w = i;
      for (int i = 7; i >= 0; i--)
      begin
         if (x[i]) c = (i == 7) ? 4'hf : 4'(2 * i + 2);
         if (m1[i]) j1 = 5'(2 * i + 2);
         if (m2[i]) j2 = 5'(2 * i + 2);
      end
      a = (w < 12) ? 16'(32'hfffe - 2 * w) : 16'hfffe;
      return {w < 12, w == 0, a, (w < 12) ? 6'(63 - w) : 6'h0, c,
         x[22] ? 4'h2 : x[23] ? 4'h4 : (x[26] & x[24]) ? 4'h6 : (x[26] & x[25]) ? 4'h8 : 4'h0,
         j1, j2, (w < 12) ? {~a[7:0], a[7:0]} : 16'h0, 1'b0};
   endfunction : expect_out
   // compare the sampled outputs with an expectation
   task automatic compare_out(input logic [58:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : compare_out
   // drive one pattern, compare one cycle later
   task automatic step(input logic [43:0] x);
      @(negedge clk);
      v = x;
      @(negedge clk);
      compare_out(expect_out(x));
   endtask : step
   // reset in mid-run with a pattern held, then the first edge after release
   task automatic reset_step(input logic [43:0] x);
      @(negedge clk);
      v = x;
      sys_rst = 1'b1;
      @(negedge clk);
      compare_out(RESET_OUT);
      sys_rst = 1'b0;
      @(negedge clk);
      compare_out(expect_out(x));
   endtask : reset_step
   task automatic complete_run;
      if (failures == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : complete_run
   // ==========================================================
   // sequence: walking ones, then sparse random patterns
   // ==========================================================
   initial
   begin
      logic [63:0] r;
      logic [31:0] s;
      void'($urandom(32'h0037));
      repeat (10) @(posedge clk);
      @(negedge clk);
      compare_out(RESET_OUT);
      sys_rst = 1'b0;
      for (int k = 0; k < 44; k++)
      begin
         step(44'h1 << k);
         step((44'h1 << k) | (44'h1 << 43));
         step((44'h1 << k) | (44'h1 << 43) | (44'h1 << 26));
      end
      step({44{1'b1}});
      reset_step({44{1'b1}});
      repeat (2000)
      begin
         r = {$urandom, $urandom} & {$urandom, $urandom} & {$urandom, $urandom};
         s = $urandom;
         r[43] = s[0];
         r[26] = s[1];
         step(r[43:0]);
         if (s[9:2] == 8'h0)
         begin
            reset_step(r[43:0]);
         end
      end
      complete_run;
   end
   // hang guard
   initial
   begin
      repeat (8000) @(posedge clk);
      failures++;
      complete_run;
   end
endmodule : tb_interrupt_vector_priority
